//--- rtl/fsc_floppy_setup_regs.sv
`timescale 1ns/1ps
`default_nettype none
module fsc_floppy_setup_regs
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CONFIG_STATE,
  input  wire logic       CSR_WR,
  input  wire logic       DATA_WR,
  input  wire logic       DATA_RD,
  input  wire logic [7:0] WDATA,
  output logic      [7:0] RDATA,
  output logic            RVALID,
  input  wire logic       DENSITY1_FORCE_BIT,
  input  wire logic       CORE_DRIVE_SEL0,
  input  wire logic       CORE_DRIVE_SEL1,
  input  wire logic       CORE_MOTOR_SEL0,
  input  wire logic       CORE_MOTOR_SEL1,
  input  wire logic [1:0] CORE_DRIVE_NUM,
  input  wire logic       CORE_DENSITY_SELECT,
  input  wire logic       CORE_DRIVE_DENSITY1,
  input  wire logic       CORE_DMA_REQ,
  input  wire logic       CORE_IRQ_REQ,
  input  wire logic       CORE_BYTE_DONE,
  input  wire logic       CORE_FIFO_EN,
  output logic      [3:0] SEL_OUT,
  output logic      [3:0] SEL_OE,
  output logic      [1:0] MOTOR_OUT,
  output logic      [1:0] MOTOR_OE,
  output logic            DENSITY_SELECT_OUT,
  output logic            DENSITY_SELECT_OE,
  output logic            DRIVE_DENSITY_OUT1,
  output logic            DRIVE_DENSITY_OE1,
  output logic            FLOPPY_DMA_REQUEST,
  output logic            FLOPPY_IRQ_REQUEST,
  output logic            PP_SEL_OUT,
  output logic            PP_SEL_OE,
  output logic [7:0]      DRIVE_TYPE_ID
);

  logic [7:0] csr_q;
  logic [7:0] setup_q;
  logic [7:0] type_q;
  logic [1:0] dens_mode;
  logic       pp;
  logic       ts;
  logic       nb;
  logic       swp;
  logic       ext4;
  logic       wr_setup;
  logic       wr_type;
  logic       rd_req;
  logic       rd_setup;
  logic       rd_type;
  logic       strobe_gap;
  logic [3:0] sel_d;
  logic [1:0] mot_d;
  logic       dens_d;
  logic       dd1_d;

  // Drive a pin value honouring open-drain mode
  function automatic logic pin_oe
  (
    input logic val,
    input logic push_pull,
    input logic tri_st
  );
    pin_oe = !tri_st && (push_pull || !val);
  endfunction : pin_oe

  // Index match in configuration state
  function automatic logic idx_hit
  (
    input logic       cfg,
    input logic [7:0] idx,
    input logic [7:0] want
  );
    idx_hit = cfg && (idx == want);
  endfunction : idx_hit

  // Density select override decode
  function automatic logic dens_sel
  (
    input logic [1:0] mode,
    input logic       core_val
  );
    case (mode)
      fsc_pkg::DENSITY_SELECT_NORMAL:     dens_sel = core_val;
      fsc_pkg::DENSITY_SELECT_RESERVED:   dens_sel = core_val;
      fsc_pkg::DENSITY_SELECT_FORCE_ONE:  dens_sel = 1'b1;
      fsc_pkg::DENSITY_SELECT_FORCE_ZERO: dens_sel = 1'b0;
      default:                    dens_sel = core_val;
    endcase
  endfunction : dens_sel

  assign pp         = setup_q[fsc_pkg::BIT_PUSH_PULL];
  assign ts         = setup_q[fsc_pkg::BIT_TRISTATE];
  assign nb         = setup_q[fsc_pkg::BIT_NON_BURST];
  assign swp        = setup_q[fsc_pkg::BIT_SWAP];
  assign ext4       = setup_q[fsc_pkg::BIT_EXT_FOUR];
  assign dens_mode  = setup_q[fsc_pkg::BIT_DENSITY_SELECT_HI:fsc_pkg::BIT_DENSITY_SELECT_LO];
  assign wr_setup   = DATA_WR && idx_hit(CONFIG_STATE, csr_q, fsc_pkg::IDX_FLOPPY_SETUP);
  assign wr_type    = DATA_WR && idx_hit(CONFIG_STATE, csr_q, fsc_pkg::IDX_DRIVE_TYPE_ID);
  assign rd_req     = CONFIG_STATE && DATA_RD;
  assign rd_setup   = DATA_RD && idx_hit(CONFIG_STATE, csr_q, fsc_pkg::IDX_FLOPPY_SETUP);
  assign rd_type    = DATA_RD && idx_hit(CONFIG_STATE, csr_q, fsc_pkg::IDX_DRIVE_TYPE_ID);
  assign strobe_gap = nb && CORE_FIFO_EN && CORE_BYTE_DONE;
  assign dd1_d      = DENSITY1_FORCE_BIT | CORE_DRIVE_DENSITY1;

  // Index register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      csr_q <= fsc_pkg::RST_CONFIG_SELECT;
    else if (CONFIG_STATE && CSR_WR)
      csr_q <= WDATA;
  end

  // Setup register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      setup_q <= fsc_pkg::RST_FLOPPY_SETUP;
    else if (wr_setup)
      setup_q <= WDATA & fsc_pkg::SETUP_WR_MASK;
  end

  // Drive type register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      type_q <= fsc_pkg::RST_DRIVE_TYPE_ID;
    else if (wr_type)
      type_q <= WDATA;
  end

  // Read strobe
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      RVALID <= 1'b0;
    else
      RVALID <= rd_req;
  end

  // Read data
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      RDATA <= 8'h00;
    else if (rd_setup)
      RDATA <= setup_q & fsc_pkg::SETUP_WR_MASK;
    else if (rd_type)
      RDATA <= type_q;
    else
      RDATA <= 8'h00;
  end

  // Drive select decode and swap
  always_comb
  begin
    sel_d = 4'h0;
    if (ext4)
      sel_d = {2'h0, CORE_DRIVE_NUM[1], CORE_DRIVE_NUM[0] ^ swp};
    else if (swp)
      sel_d = {2'h0, CORE_DRIVE_SEL0, CORE_DRIVE_SEL1};
    else
      sel_d = {2'h0, CORE_DRIVE_SEL1, CORE_DRIVE_SEL0};
  end

  // Motor select swap
  always_comb
  begin
    if (swp)
      mot_d = {CORE_MOTOR_SEL0, CORE_MOTOR_SEL1};
    else
      mot_d = {CORE_MOTOR_SEL1, CORE_MOTOR_SEL0};
  end

  // Density select override
  always_comb
  begin
    dens_d = dens_sel(dens_mode, CORE_DENSITY_SELECT);
  end

  // Drive select pins
  for (genvar g = 0; g < fsc_pkg::NUM_DRIVES; g++)
  begin : g_sel
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
      begin
        SEL_OUT[g] <= 1'b0;
        SEL_OE[g]  <= 1'b0;
      end
      else
      begin
        SEL_OUT[g] <= sel_d[g];
        SEL_OE[g]  <= pin_oe(sel_d[g], pp, ts);
      end
    end
  end

  // Motor select pins
  for (genvar g = 0; g < $bits(mot_d); g++)
  begin : g_mot
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
      begin
        MOTOR_OUT[g] <= 1'b0;
        MOTOR_OE[g]  <= 1'b0;
      end
      else
      begin
        MOTOR_OUT[g] <= mot_d[g];
        MOTOR_OE[g]  <= pin_oe(mot_d[g], pp, ts);
      end
    end
  end

  // Density select pin
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      DENSITY_SELECT_OUT <= 1'b0;
      DENSITY_SELECT_OE  <= 1'b0;
    end
    else
    begin
      DENSITY_SELECT_OUT <= dens_d;
      DENSITY_SELECT_OE  <= pin_oe(dens_d, pp, ts);
    end
  end

  // Drive density 1 pin
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      DRIVE_DENSITY_OUT1 <= 1'b0;
      DRIVE_DENSITY_OE1  <= 1'b0;
    end
    else
    begin
      DRIVE_DENSITY_OUT1 <= dd1_d;
      DRIVE_DENSITY_OE1  <= pin_oe(dd1_d, pp, ts);
    end
  end

  // Parallel-port floppy path ignores output bits
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      PP_SEL_OUT <= 1'b0;
      PP_SEL_OE  <= 1'b0;
    end
    else
    begin
      PP_SEL_OUT <= sel_d[0];
      PP_SEL_OE  <= 1'b1;
    end
  end

  // DMA request, one gap per byte in non-burst with FIFO enabled
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      FLOPPY_DMA_REQUEST <= 1'b0;
    else if (strobe_gap)
      FLOPPY_DMA_REQUEST <= 1'b0;
    else
      FLOPPY_DMA_REQUEST <= CORE_DMA_REQ;
  end

  // Interrupt request, one gap per byte in non-burst with FIFO enabled
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      FLOPPY_IRQ_REQUEST <= 1'b0;
    else if (strobe_gap)
      FLOPPY_IRQ_REQUEST <= 1'b0;
    else
      FLOPPY_IRQ_REQUEST <= CORE_IRQ_REQ;
  end

  // Drive type export
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      DRIVE_TYPE_ID <= fsc_pkg::RST_DRIVE_TYPE_ID;
    else
      DRIVE_TYPE_ID <= type_q;
  end

endmodule : fsc_floppy_setup_regs
`default_nettype wire

//--- rtl/fsc_pkg.sv
package fsc_pkg;
  localparam logic [7:0] IDX_FLOPPY_SETUP   = 8'h05;
  localparam logic [7:0] IDX_DRIVE_TYPE_ID  = 8'h06;
  localparam logic [7:0] RST_FLOPPY_SETUP   = 8'h00;
  localparam logic [7:0] RST_DRIVE_TYPE_ID  = 8'hff;
  localparam logic [7:0] RST_CONFIG_SELECT  = 8'h00;
  localparam int         BIT_PUSH_PULL      = 0;
  localparam int         BIT_TRISTATE       = 1;
  localparam int         BIT_NON_BURST      = 2;
  localparam int         BIT_DENSITY_SELECT_LO      = 3;
  localparam int         BIT_DENSITY_SELECT_HI      = 4;
  localparam int         BIT_SWAP           = 5;
  localparam int         BIT_EXT_FOUR       = 6;
  localparam logic [7:0] SETUP_WR_MASK      = 8'h7f;
  localparam logic [1:0] DENSITY_SELECT_NORMAL      = 2'h0;
  localparam logic [1:0] DENSITY_SELECT_RESERVED    = 2'h1;
  localparam logic [1:0] DENSITY_SELECT_FORCE_ONE   = 2'h2;
  localparam logic [1:0] DENSITY_SELECT_FORCE_ZERO  = 2'h3;
  localparam int         TYPE_ID_WIDTH      = 2;
  localparam int         NUM_DRIVES         = 4;
endpackage : fsc_pkg

//--- verification/fsc_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsc_drive_model
(
  input  wire logic [3:0] sel_out,
  input  wire logic [3:0] sel_oe,
  input  wire logic       dd1_out,
  input  wire logic       dd1_oe,
  output logic      [3:0] sel_lvl,
  output logic            dd1_lvl,
  output logic      [3:0] dec
);
  // Pull-ups hold released lines high
  assign sel_lvl = sel_out | ~sel_oe;
  assign dd1_lvl = dd1_out | ~dd1_oe;
  assign dec = 4'h1 << sel_lvl[1:0];
endmodule : fsc_drive_model
`default_nettype wire

//--- verification/fsc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fsc_sva
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CONFIG_STATE,
  input wire logic       CSR_WR,
  input wire logic       DATA_WR,
  input wire logic       DATA_RD,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic       RVALID,
  input wire logic       CORE_DENSITY_SELECT,
  input wire logic       CORE_DMA_REQ,
  input wire logic       CORE_BYTE_DONE,
  input wire logic       CORE_FIFO_EN,
  input wire logic [3:0] SEL_OUT,
  input wire logic [3:0] SEL_OE,
  input wire logic       DENSITY_SELECT_OUT,
  input wire logic       FLOPPY_DMA_REQUEST,
  input wire logic       PP_SEL_OE,
  input wire logic       CORE_IRQ_REQ,
  input wire logic       CORE_MOTOR_SEL0,
  input wire logic       CORE_MOTOR_SEL1,
  input wire logic [1:0] MOTOR_OUT,
  input wire logic [1:0] MOTOR_OE,
  input wire logic       DENSITY_SELECT_OE,
  input wire logic       FLOPPY_IRQ_REQUEST,
  input wire logic       PP_SEL_OUT,
  input wire logic       DRIVE_DENSITY_OUT1,
  input wire logic       DRIVE_DENSITY_OE1,
  input wire logic       DENSITY1_FORCE_BIT,
  input wire logic       CORE_DRIVE_DENSITY1
);
  logic [7:0] ix_q, st_q, ty_q;
  wire  [7:0] rx = ix_q == 8'h05 ? st_q : ix_q == 8'h06 ? ty_q : 8'h00;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Shadow copy of the register bank
  always_ff @(posedge CLK or posedge RST)
    if (RST) {ix_q, st_q, ty_q} <= 24'h0000ff;
    else if (CONFIG_STATE)
    begin
      if (CSR_WR) ix_q <= WDATA;
      if (DATA_WR && ix_q == 8'h05) st_q <= WDATA & 8'h7f;
      if (DATA_WR && ix_q == 8'h06) ty_q <= WDATA;
    end
  property p_oe; !$past(RST) |->
    SEL_OE[0] == (!$past(st_q[1]) && ($past(st_q[0]) || !SEL_OUT[0])); endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_nb; !$past(RST) |-> FLOPPY_DMA_REQUEST ==
    $past(CORE_DMA_REQ && !(st_q[2] && CORE_FIFO_EN && CORE_BYTE_DONE)); endproperty
  a_nb: assert property (p_nb) else $error("nb");
  property p_ds; !$past(RST) |-> DENSITY_SELECT_OUT ==
    ($past(st_q[4]) ? !$past(st_q[3]) : $past(CORE_DENSITY_SELECT)); endproperty
  a_ds: assert property (p_ds) else $error("ds");
  property p_tri; $past(st_q[1]) |-> SEL_OE == 4'h0; endproperty
  a_tri: assert property (p_tri) else $error("tri");
  property p_pp; !$past(RST) |-> PP_SEL_OE; endproperty
  a_pp: assert property (p_pp) else $error("pp");
  property p_rd; CONFIG_STATE && DATA_RD |=> RDATA == $past(rx); endproperty
  a_rd: assert property (p_rd) else $error("rd");
  property p_rz; !(CONFIG_STATE && DATA_RD) |=> RDATA == 8'h00; endproperty
  a_rz: assert property (p_rz) else $error("rz");
  property p_rv; !$past(RST) |-> RVALID == $past(CONFIG_STATE && DATA_RD); endproperty
  a_rv: assert property (p_rv) else $error("rv");
  property p_irq; !$past(RST) |-> FLOPPY_IRQ_REQUEST ==
    $past(CORE_IRQ_REQ && !(st_q[2] && CORE_FIFO_EN && CORE_BYTE_DONE)); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_mot; !$past(RST) |-> MOTOR_OUT == ($past(st_q[5]) ?
    $past({CORE_MOTOR_SEL0, CORE_MOTOR_SEL1}) : $past({CORE_MOTOR_SEL1, CORE_MOTOR_SEL0}));
  endproperty
  a_mot: assert property (p_mot) else $error("mot");
  property p_ftri; $past(st_q[1]) |->
    MOTOR_OE == 2'h0 && !DENSITY_SELECT_OE && !DRIVE_DENSITY_OE1; endproperty
  a_ftri: assert property (p_ftri) else $error("ftri");
  property p_dd1; !$past(RST) |->
    DRIVE_DENSITY_OUT1 == $past(DENSITY1_FORCE_BIT || CORE_DRIVE_DENSITY1); endproperty
  a_dd1: assert property (p_dd1) else $error("dd1");
  property p_dsoe; !$past(RST) && !$past(st_q[1]) |->
    DENSITY_SELECT_OE == ($past(st_q[0]) || !DENSITY_SELECT_OUT); endproperty
  a_dsoe: assert property (p_dsoe) else $error("dsoe");
  property p_ppo; !$past(RST) |-> PP_SEL_OUT == SEL_OUT[0]; endproperty
  a_ppo: assert property (p_ppo) else $error("ppo");
endmodule : fsc_sva
bind fsc_floppy_setup_regs fsc_sva u_sva (.*);
`default_nettype wire

//--- verification/tb_floppy_setup_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_floppy_setup_config_regs;
  logic CLK = 0, RST = 1, CONFIG_STATE = 1, CSR_WR = 0, DATA_WR = 0, DATA_RD = 0, rnd = 1;
  logic [12:0] c = '0;
  logic [7:0] WDATA = '0, RDATA, DRIVE_TYPE_ID, t, v;
  logic [3:0] SEL_OUT, SEL_OE, lvl, dec;
  logic RVALID, DRIVE_DENSITY_OUT1, DRIVE_DENSITY_OE1, PP_SEL_OE, dl;
  int err_count = 0, n_compared = 0, cyc = 0;
  fsc_floppy_setup_regs u_dut (.*, .DENSITY1_FORCE_BIT(c[0]), .CORE_DRIVE_SEL0(c[1]),
    .CORE_DRIVE_SEL1(c[2]), .CORE_MOTOR_SEL0(c[3]), .CORE_MOTOR_SEL1(c[4]),
    .CORE_DRIVE_NUM(c[6:5]), .CORE_DENSITY_SELECT(c[7]), .CORE_DRIVE_DENSITY1(c[8]),
    .CORE_DMA_REQ(c[9]), .CORE_IRQ_REQ(c[10]), .CORE_BYTE_DONE(c[11]),
    .CORE_FIFO_EN(c[12]), .MOTOR_OUT(), .MOTOR_OE(), .DENSITY_SELECT_OUT(),
    .DENSITY_SELECT_OE(), .FLOPPY_DMA_REQUEST(), .FLOPPY_IRQ_REQUEST(), .PP_SEL_OUT());
  fsc_drive_model u_drv (.sel_out(SEL_OUT), .sel_oe(SEL_OE), .dd1_out(DRIVE_DENSITY_OUT1),
    .dd1_oe(DRIVE_DENSITY_OE1), .sel_lvl(lvl), .dd1_lvl(dl), .dec);
  task end_sim(input int e);
    err_count += e;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task chk(input logic [8:0] s, e);
    n_compared++;
    if (s !== e) err_count++;
    if (s !== e) $display("ERROR %0t: got %h want %h", $time, s, e);
  endtask : chk
  task op(input logic [2:0] k, input logic [7:0] d);
    @(posedge CLK);
    #1;
    {CSR_WR, DATA_WR, DATA_RD} = k;
    WDATA = d;
    if (rnd) c = 13'($urandom);
  endtask : op
  task rd(input logic [8:0] e);
    op(3'h1, 8'h00);
    op(3'h0, 8'h00);
    chk({RVALID, RDATA}, e);
  endtask : rd
  task wr(input logic [7:0] i, d, input logic p);
    op(3'h4, i);
    op(3'h2, d);
    if (p) repeat (2) op(3'h0, 8'h00);
  endtask : wr
  always #5 CLK = ~CLK;
  always @(posedge CLK)
    if (++cyc == 3000) end_sim(1);
  initial
  begin
    v = $urandom(32'h44e55e28);
    repeat (10) @(posedge CLK);
    #1;
    RST = 0;
    chk(DRIVE_TYPE_ID, 8'hff);
    op(3'h4, 8'h05);
    rd(9'h100);
    op(3'h4, 8'h06);
    rd(9'h1ff);
    $display("reset test done");
    for (int i = 0; i < 12; i++)
    begin
      t = $urandom;
      v = $urandom;
      v[4:3] = i[1:0];
      wr(8'h06, t, 0);
      rd({1'b1, t});
      wr(8'h05, v, 0);
      rd({1'b1, v & 8'h7f});
    end
    $display("random test done");
    rnd = 0;
    CONFIG_STATE = 0;
    wr(8'h06, 8'h00, 0);
    rd(9'h000);
    CONFIG_STATE = 1;
    op(3'h4, 8'h06);
    rd({1'b1, t});
    wr(8'h07, 8'h55, 0);
    rd(9'h100);
    c = 13'h0043;
    wr(8'h05, 8'h00, 1);
    chk(SEL_OE[1:0], 2'h2);
    wr(8'h05, 8'h21, 1);
    chk({lvl[1:0], dl}, 3'h5);
    wr(8'h05, 8'h61, 1);
    chk(dec, 4'h8);
    wr(8'h05, 8'h02, 1);
    chk({lvl, DRIVE_DENSITY_OE1, PP_SEL_OE}, 6'h3d);
    $display("corner test done");
    end_sim(0);
  end
endmodule : tb_floppy_setup_config_regs
`default_nettype wire
